// ===== rtl/eeprom_rd_pkg.sv
package eeprom_rd_pkg;
   // array geometry
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int MEM_WORDS = 131072;
   // device address byte layout
   localparam int DEVB_RW_BIT = 0;
   localparam int DEVB_TOP_BIT = 1;
   localparam int DEVB_STRAP_LO_BIT = 2;
   localparam int DEVB_STRAP_HI_BIT = 3;
   localparam int DEVB_TYPE_LSB = 4;
   // type identifier, value arbitrary
   localparam logic [3:0] DEV_TYPE_ID = 4'h5;
   // reset and erased values, byte bit counts
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_TX_BIT = 4'h7;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX   = 3'h1,
      ST_ACK  = 3'h3,
      ST_TX   = 3'h2,
      ST_MACK = 3'h6
   } link_state_t;

   typedef enum logic [1:0] {
      RX_DEV     = 2'h0,
      RX_ADDR_HI = 2'h1,
      RX_ADDR_LO = 2'h3,
      RX_DATA    = 2'h2
   } rx_kind_t;
endpackage

// ===== rtl/fifo_buf.sv
`timescale 1ns/1ps
module fifo_buf
   import eeprom_rd_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             flush,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr_ptr;
      logic [PW-1:0] rd_ptr;
      logic [PW:0]   count;
   } fifo_state_t;

   fifo_state_t            s;
   fifo_state_t            next_s;
   logic       [WIDTH-1:0] mem [DEPTH];
   logic                   push;
   logic                   pop;

   assign in_ready = (s.count != (PW+1)'(DEPTH));
   assign out_valid = (s.count != '0);
   assign out_data = mem[s.rd_ptr];
   assign push = in_valid & in_ready & ~flush;
   assign pop = out_valid & out_ready & ~flush;

   always_comb begin
      next_s = s;
      if (flush) begin
         next_s = '0;
      end else begin
         if (push) begin
            next_s.wr_ptr = s.wr_ptr + PW'(1);
         end
         if (pop) begin
            next_s.rd_ptr = s.rd_ptr + PW'(1);
         end
         next_s.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // storage needs no reset; count guards every read
   always_ff @(posedge clock) begin
      if (push) begin
         mem[s.wr_ptr] <= in_data;
      end
   end
endmodule

// ===== rtl/eeprom_read_engine.sv
`timescale 1ns/1ps
// Function
// - read/write bit one selects a read
// - counter holds last address plus one
// - counter wraps from last to first byte
// - current read: ack, send byte at counter
// - master nack ends read, release data
// - repeated start read sends loaded address byte
// - master ack: increment, send next byte
// - sequential read wraps to array start
// - unwritten array reads back FF
// - device byte: straps, top bit, rw
// - two address bytes, high first, acked
// - mismatched device byte gets nack, ignored
// - no device ack during write cycle
module eeprom_read_engine
   import eeprom_rd_pkg::*;
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              nrst,
   // two-wire link pins
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe_n,
   // strap pins
   input  wire logic              chip_select_strap_high,
   input  wire logic              chip_select_strap_low,
   // neighbouring write engine
   input  wire logic              write_cycle_busy,
   // status
   output logic      [ADDR_W-1:0] word_addr
);
   typedef struct packed {
      logic              scl_s1;
      logic              scl_s2;
      logic              scl_d;
      logic              sda_s1;
      logic              sda_s2;
      logic              sda_d;
      logic              hi_s1;
      logic              hi_s2;
      logic              lo_s1;
      logic              lo_s2;
      link_state_t       state;
      rx_kind_t          kind;
      logic [3:0]        bit_cnt;
      logic [7:0]        shreg;
      logic              read_mode;
      logic              top_bit;
      logic [7:0]        hi_byte;
      logic              oe_n;
      logic [ADDR_W-1:0] word_addr;
      logic [ADDR_W-1:0] fetch_addr;
      logic              q_valid;
   } eng_state_t;

   eng_state_t              s;
   eng_state_t              next_s;
   logic       [1:0]        rst_pipe;
   logic                    rst_n;
   logic       [DATA_W-1:0] mem [MEM_WORDS];
   logic       [DATA_W-1:0] ram_q;
   logic                    issue;
   logic                    flush;
   logic                    pop;
   logic                    fifo_in_ready;
   logic                    fifo_out_valid;
   logic       [DATA_W-1:0] fifo_data;
   logic                    scl_rise;
   logic                    scl_fall;
   logic                    start_cond;
   logic                    stop_cond;
   logic                    dev_match;

   // delivered state of the array
   initial begin
      for (int i = 0; i < MEM_WORDS; i++) begin
         mem[i] = ERASED_BYTE;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // edges seen on the second and third sync stages only
   assign scl_rise = s.scl_s2 & ~s.scl_d;
   assign scl_fall = ~s.scl_s2 & s.scl_d;
   assign start_cond = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
   assign stop_cond = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;

   // shreg holds the fully shifted device byte here
   assign dev_match = (s.shreg[7:DEVB_TYPE_LSB] == DEV_TYPE_ID)
                    & (s.shreg[DEVB_STRAP_HI_BIT] == s.hi_s2)
                    & (s.shreg[DEVB_STRAP_LO_BIT] == s.lo_s2)
                    & ~write_cycle_busy;

   always_comb begin
      next_s = s;
      flush = 1'b0;
      pop = 1'b0;
      next_s.scl_s1 = scl_in;
      next_s.scl_s2 = s.scl_s1;
      next_s.scl_d = s.scl_s2;
      next_s.sda_s1 = sda_in;
      next_s.sda_s2 = s.sda_s1;
      next_s.sda_d = s.sda_s2;
      next_s.hi_s1 = chip_select_strap_high;
      next_s.hi_s2 = s.hi_s1;
      next_s.lo_s1 = chip_select_strap_low;
      next_s.lo_s2 = s.lo_s1;
      if (start_cond) begin
         // a start wins over anything in flight, also after a nack
         next_s.state = ST_RX;
         next_s.kind = RX_DEV;
         next_s.bit_cnt = 4'h0;
         next_s.oe_n = 1'b1;
      end else if (stop_cond) begin
         next_s.state = ST_IDLE;
         next_s.oe_n = 1'b1;
      end else begin
         case (s.state)
            ST_IDLE: begin
               next_s.oe_n = 1'b1;
            end
            ST_RX: begin
               if (scl_rise) begin
                  next_s.shreg = {s.shreg[6:0], s.sda_s2};
                  next_s.bit_cnt = s.bit_cnt + 4'h1;
               end else if (scl_fall && s.bit_cnt == BYTE_BITS) begin
                  next_s.bit_cnt = 4'h0;
                  next_s.state = ST_ACK;
                  next_s.oe_n = 1'b0;
                  case (s.kind)
                     RX_DEV: begin
                        next_s.read_mode = s.shreg[DEVB_RW_BIT];
                        next_s.top_bit = s.shreg[DEVB_TOP_BIT];
                        if (!dev_match) begin
                           next_s.state = ST_IDLE;
                           next_s.oe_n = 1'b1;
                        end
                     end
                     RX_ADDR_HI: begin
                        next_s.hi_byte = s.shreg;
                     end
                     RX_ADDR_LO: begin
                        // load now: no data byte or stop is needed
                        next_s.word_addr = {s.top_bit, s.hi_byte, s.shreg};
                        next_s.fetch_addr = {s.top_bit, s.hi_byte, s.shreg};
                        flush = 1'b1;
                     end
                     default: begin
                        // write data belongs to the write engine; acked, dropped
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  next_s.oe_n = 1'b1;
                  if (s.kind == RX_DEV && s.read_mode) begin
                     // head of the prefetch queue is the byte at the counter
                     pop = 1'b1;
                     next_s.word_addr = s.word_addr + 17'h00001;
                     next_s.shreg = fifo_data;
                     next_s.oe_n = fifo_data[7];
                     next_s.state = ST_TX;
                  end else begin
                     next_s.state = ST_RX;
                     case (s.kind)
                        RX_DEV: next_s.kind = RX_ADDR_HI;
                        RX_ADDR_HI: next_s.kind = RX_ADDR_LO;
                        default: next_s.kind = RX_DATA;
                     endcase
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (s.bit_cnt == LAST_TX_BIT) begin
                     next_s.oe_n = 1'b1;
                     next_s.state = ST_MACK;
                  end else begin
                     next_s.shreg = {s.shreg[6:0], 1'b0};
                     next_s.oe_n = s.shreg[6];
                     next_s.bit_cnt = s.bit_cnt + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  // low means ack: next byte; high means nack: done, released
                  next_s.state = s.sda_s2 ? ST_IDLE : ST_ACK;
                  next_s.bit_cnt = 4'h0;
               end
            end
            default: begin
               next_s.state = ST_IDLE;
               next_s.oe_n = 1'b1;
            end
         endcase
      end
      // prefetch one word per cycle while the queue has room
      issue = (~s.q_valid | fifo_in_ready) & ~flush;
      if (flush) begin
         next_s.q_valid = 1'b0;
      end else if (issue) begin
         next_s.fetch_addr = s.fetch_addr + 17'h00001;
         next_s.q_valid = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s <= '{
            state: ST_IDLE, kind: RX_DEV, bit_cnt: 4'h0, shreg: 8'h00,
            hi_byte: 8'h00, oe_n: 1'b1, word_addr: ADDR_RESET,
            fetch_addr: ADDR_RESET, scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
            sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1, default: 1'b0
         };
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge clock) begin
      if (issue) begin
         ram_q <= mem[s.fetch_addr];
      end
   end

   fifo_buf #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_prefetch (
      .clock     (clock),
      .rst_n     (rst_n),
      .flush     (flush),
      .in_valid  (s.q_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (ram_q),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (fifo_data)
   );

   // open-drain: the line is only ever pulled low
   assign sda_out = 1'b0;
   assign sda_oe_n = s.oe_n;
   assign word_addr = s.word_addr;
endmodule

// ===== tb/read_engine_asserts.sv
`timescale 1ns/1ps
module read_engine_asserts
   import eeprom_rd_pkg::*;
(
   // clock and reset
   input wire logic              clock,
   input wire logic              nrst,
   // link pins
   input wire logic              scl_in,
   input wire logic              sda_in,
   input wire logic              sda_out,
   input wire logic              sda_oe_n,
   // straps and write engine
   input wire logic              chip_select_strap_high,
   input wire logic              chip_select_strap_low,
   input wire logic              write_cycle_busy,
   // status
   input wire logic [ADDR_W-1:0] word_addr
);
   typedef struct packed {
      logic       scl_q;
      logic [3:0] since_fall;
   } watch_t;
   watch_t watch;
   watch_t next_watch;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   // clocks since the link clock was last seen falling, saturating
   always_comb begin
      next_watch.scl_q = scl_in;
      next_watch.since_fall = (watch.since_fall == 4'hF) ? 4'hF : watch.since_fall + 4'h1;
      if (watch.scl_q && !scl_in) begin
         next_watch.since_fall = 4'h0;
      end
   end
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         watch <= '{scl_q: 1'b1, since_fall: 4'hF};
      end else begin
         watch <= next_watch;
      end
   end
   a_pin_low_only: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_ack_after_fall: assert property ($fell(sda_oe_n) |-> watch.since_fall <= 4'h5)
      else $error("drive started away from a clock fall");
   a_release_after_fall: assert property ($rose(sda_oe_n) |-> watch.since_fall <= 4'h5)
      else $error("release away from a clock fall");
   a_addr_after_fall: assert property ($changed(word_addr) |-> watch.since_fall <= 4'h5)
      else $error("counter moved away from a clock fall");
   a_busy_refuses: assert property (write_cycle_busy [*8] |-> sda_oe_n)
      else $error("drive while write cycle busy");
   // the first edge under reset still sees power-up values, so look one edge later
   a_reset_quiet: assert property (disable iff (1'b0) !nrst ##1 !nrst |-> sda_oe_n && word_addr == ADDR_RESET)
      else $error("reset values wrong");
   a_stop_quiet: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##4 sda_oe_n [*8])
      else $error("drive right after stop");
   a_idle_keeps_addr: assert property (scl_in [*8] |-> $stable(word_addr))
      else $error("counter moved on idle link");
endmodule
bind eeprom_read_engine read_engine_asserts u_asserts (
   .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .chip_select_strap_high(chip_select_strap_high), .chip_select_strap_low(chip_select_strap_low),
   .write_cycle_busy(write_cycle_busy), .word_addr(word_addr)
);

// ===== tb/link_master_model.sv
`timescale 1ns/1ps
module link_master_model (
   // clock
   input  wire logic clock,
   // link pins, data is open drain
   input  wire logic sda,
   output logic      scl,
   output logic      sda_m
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // link clock stands high outside frames
   task automatic start();
      sda_m = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_m = 1'b0;
      tick(4);
      scl = 1'b0;
      tick(1);
   endtask
   task automatic stop();
      sda_m = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_m = 1'b1;
      tick(4);
   endtask
   // nine bits msb first; data moves one clock after the fall, never beside it
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_m = tx[i];
         tick(3);
         scl = 1'b1;
         tick(3);
         rx[i] = sda;
         tick(1);
         scl = 1'b0;
         tick(1);
      end
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb
   import eeprom_rd_pkg::*;
;
   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic              busy = 1'b0;
   logic              sda_out;
   logic              sda_oe_n;
   logic [ADDR_W-1:0] word_addr;
   logic [8:0]        rx;
   wire               scl;
   wire               sda_m;
   wire               sda;
   int                mismatches = 0;
   int                n_compared = 0;
   localparam logic [ADDR_W-1:0] SEQ [3] = '{17'h1FFFF, 17'h00000, 17'h00001};
   // stands in for an earlier write; not bit-symmetric, so shift order shows
   localparam logic [DATA_W-1:0] PLANTED = 8'h1E;
   always #25 clock = ~clock;
   assign sda = sda_m & (sda_oe_n | sda_out);
   eeprom_read_engine DUT (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .chip_select_strap_high(1'b1), .chip_select_strap_low(1'b0),
      .write_cycle_busy(busy), .word_addr(word_addr));
   link_master_model master (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
   function automatic logic [8:0] dev(input logic top, input logic rd);
      return {DEV_TYPE_ID, 2'b10, top, rd, 1'b1};
   endfunction
   task automatic chk(input string what, input logic [ADDR_W-1:0] exp, input logic [ADDR_W-1:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         mismatches++;
      end
   endtask
   task automatic chk_ack(input string what, input logic exp);
      chk(what, ADDR_W'(exp), ADDR_W'(rx[0]));
   endtask
   task automatic t_refuse();
      logic [8:0] bad [3];
      bad = '{{DEV_TYPE_ID ^ 4'h3, 2'b10, 3'b011}, {DEV_TYPE_ID, 2'b01, 3'b011}, dev(1'b0, 1'b1)};
      for (int i = 0; i < 3; i++) begin
         busy = (i == 2);
         master.start();
         master.xfer(bad[i], rx);
         chk_ack("refused ack", 1'b1);
      end
      busy = 1'b0;
      master.stop();
      chk("idle counter", 17'h00000, word_addr);
   endtask
   task automatic t_random();
      master.start();
      master.xfer(dev(1'b1, 1'b0), rx);
      chk_ack("write dev ack", 1'b0);
      master.xfer({8'hFF, 1'b1}, rx);
      chk_ack("high addr ack", 1'b0);
      master.xfer({8'hFE, 1'b1}, rx);
      chk_ack("low addr ack", 1'b0);
      chk("loaded counter", 17'h1FFFE, word_addr);
      master.start();
      master.xfer(dev(1'b0, 1'b1), rx);
      chk_ack("read dev ack", 1'b0);
      for (int i = 0; i < 3; i++) begin
         master.xfer({8'hFF, i == 2}, rx);
         chk("read byte", ADDR_W'((i == 2) ? PLANTED : ERASED_BYTE), ADDR_W'(rx[8:1]));
         chk("counter", SEQ[i], word_addr);
      end
      master.stop();
      chk("released", 17'h00001, ADDR_W'(sda_oe_n));
      chk("counter after nack", 17'h00001, word_addr);
   endtask
   task automatic t_current();
      for (int i = 0; i < 2; i++) begin
         master.start();
         master.xfer(dev(1'b0, 1'b1), rx);
         chk_ack("current ack", 1'b0);
         master.xfer({8'hFF, 1'b1}, rx);
         chk("current byte", ADDR_W'(ERASED_BYTE), ADDR_W'(rx[8:1]));
         chk("current counter", ADDR_W'(i + 2), word_addr);
      end
      master.stop();
   endtask
   task automatic t_load_stop();
      master.start();
      master.xfer(dev(1'b0, 1'b0), rx);
      chk_ack("write dev ack", 1'b0);
      master.xfer({8'h00, 1'b1}, rx);
      chk_ack("high addr ack", 1'b0);
      master.xfer({8'h05, 1'b1}, rx);
      chk_ack("low addr ack", 1'b0);
      master.stop();
      chk("counter kept", 17'h00005, word_addr);
      master.start();
      master.xfer(dev(1'b0, 1'b1), rx);
      chk_ack("current ack", 1'b0);
      master.xfer({8'hFF, 1'b1}, rx);
      chk("current byte", ADDR_W'(ERASED_BYTE), ADDR_W'(rx[8:1]));
      chk("counter", 17'h00006, word_addr);
      master.start();
      master.xfer(dev(1'b0, 1'b0), rx);
      master.xfer({8'h00, 1'b1}, rx);
      master.xfer({8'h07, 1'b1}, rx);
      master.xfer({8'h3C, 1'b1}, rx);
      chk_ack("data byte ack", 1'b0);
      master.stop();
   endtask
   task automatic test_done();
      if (mismatches == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clock);
      DUT.mem[17'h00000] = PLANTED;
      nrst = 1'b1;
      repeat (8) @(negedge clock);
      t_refuse();
      t_random();
      t_current();
      t_load_stop();
      test_done();
   end
   // whole run is about 1900 clocks
   initial begin
      repeat (4000) @(posedge clock);
      mismatches++;
      test_done();
   end
endmodule
